// *** rtl/tci_pkg.sv ***
// shared constants and state types for the touch controller two-wire port
package tci_pkg;
    localparam logic [7:0] ADDR_PAIR_A = 8'hBA; // selected when the event line is low
    localparam logic [7:0] ADDR_PAIR_B = 8'h28; // selected when the event line is high
    localparam int CLK_HZ = 100000000;
    localparam int BIT_RATE_HZ = 400000;
    // quarter bit rounded up so the bit rate never exceeds the limit
    localparam int QTR_CYC = (CLK_HZ + 4 * BIT_RATE_HZ - 1) / (4 * BIT_RATE_HZ);
    localparam int PTR_W = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] SEL_SETTLE = 2'h3;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_PHI = 2'h1;
    localparam logic [1:0] PH_PLO = 2'h2;
    localparam logic [1:0] PH_DATA = 2'h3;
    localparam logic [2:0] STG_ADDRW = 3'h0;
    localparam logic [2:0] STG_HI = 3'h1;
    localparam logic [2:0] STG_LO = 3'h2;
    localparam logic [2:0] STG_WDATA = 3'h3;
    localparam logic [2:0] STG_ADDRR = 3'h4;
    localparam logic [2:0] STG_RDATA = 3'h5;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } tci_dev_e;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BITS = 4'h4,
        H_STOP = 4'h8
    } tci_host_e;
endpackage

// *** rtl/tci_if.sv ***
// open-drain two-wire link between host and touch controller
`timescale 1ns/1ps
interface tci_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic evt_sel;
    logic scl;
    logic sda;
    // pull-up gives the high level; any enabled low driver wins
    assign scl = (scl_host_oe && !scl_host_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o)) ? 1'b0 : 1'b1;
    modport dev (input scl, input sda, input evt_sel, output sda_dev_o, output sda_dev_oe);
    modport host (input sda, output scl_host_o, output scl_host_oe, output sda_host_o,
                  output sda_host_oe, output evt_sel);
endinterface

// *** rtl/tci_sync.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module tci_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '1;
            q_o <= '1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // tci_sync

// *** rtl/tci_dev.sv ***
// touch controller end: two-wire slave into a 16-bit register space
`timescale 1ns/1ps
// How it works
// RULE1: slave only, never starts a transfer
// RULE2: host keeps bit rate at most 400kbps
// RULE3: answer only selected pair BA/BB or 28/29
// RULE4: host picks pair with reset and event line
// RULE5: event line latched after reset release
// RULE6: SDA falls while SCL high means start
// RULE7: capture address byte after start, compare
// RULE8: matching address acked low in ninth clock
// RULE9: other addresses ignored until next start
// RULE10: eight data bits then one ack bit
// RULE11: sample while SCL high, change while low
// RULE12: SDA rises while SCL high means stop
// RULE13: write: address, 16-bit pointer, data bytes
// RULE14: pointer high byte first, bits MSB first
// RULE15: pointer advances by one per written byte
// RULE16: burst write runs until stop
// RULE17: read begins by writing the pointer
// RULE18: repeated start, read address, then data out
// RULE19: burst read while host keeps acking
// RULE20: host nacks last byte; device releases SDA
// RULE21: SDA driven low or released only
module tci_dev (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    tci_if.dev link,
    output logic [tci_pkg::PTR_W-1:0] reg_addr_o,
    output logic wr_en_o,
    output logic [7:0] wr_data_o,
    output logic rd_en_o,
    input wire logic [7:0] rd_data_i,
    output logic busy_o,
    output logic [7:0] addr_pair_o
);
    tci_pkg::tci_dev_e state;

    logic scl_s;
    logic sda_s;
    logic evt_s;

    logic scl_q;
    logic sda_q;

    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;

    logic [1:0] ph;
    logic rnw;
    logic nak;
    logic drv;

    logic pair_b;
    logic [1:0] sel_cnt;

    logic [tci_pkg::PTR_W-1:0] ptr;

    tci_sync #(.W(3)) u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({link.scl, link.sda, link.evt_sel}),
        .q_o({scl_s, sda_s, evt_s})
    );

    wire scl_rise = scl_s & ~scl_q; // [RULE11]
    wire scl_fall = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s; // [RULE6]
    wire stop_det = scl_s & scl_q & ~sda_q & sda_s; // [RULE12]

    wire byte_done = scl_fall && (cnt == tci_pkg::BYTE_BITS); // [RULE10]
    wire addr_hit = (shift[7:1] == addr_pair_o[7:1]); // [RULE3] [RULE7]
    wire pass_ack = (ph == tci_pkg::PH_ADDR) && rnw;

    assign addr_pair_o = pair_b ? tci_pkg::ADDR_PAIR_B : tci_pkg::ADDR_PAIR_A;
    assign reg_addr_o = ptr;
    assign busy_o = (state != tci_pkg::ST_IDLE);

    // only ever pulls low; the pull-up makes the high level
    assign link.sda_dev_o = 1'b0; // [RULE21]
    assign link.sda_dev_oe = drv;

    // strap follows the synchronised line for a few edges, then freezes
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_cnt <= 2'h0;
            pair_b <= 1'b0;
        end else if (sel_cnt != tci_pkg::SEL_SETTLE) begin
            sel_cnt <= sel_cnt + 2'h1;
            pair_b <= evt_s; // [RULE5] [RULE4]
        end
    end

    // never drives SCL and only reacts to a host start
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= tci_pkg::ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ph <= tci_pkg::PH_ADDR;
            rnw <= 1'b0;
            nak <= 1'b0;
            drv <= 1'b0;
            ptr <= 16'h0000;
            wr_en_o <= 1'b0;
            wr_data_o <= 8'h00;
            rd_en_o <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            wr_en_o <= 1'b0;
            rd_en_o <= 1'b0;

            if (start_det) begin // [RULE1] [RULE6]
                state <= tci_pkg::ST_RX;
                ph <= tci_pkg::PH_ADDR;
                cnt <= 4'h0;
                drv <= 1'b0;
            end else if (stop_det) begin
                state <= tci_pkg::ST_IDLE; // [RULE12] [RULE16]
                drv <= 1'b0;
            end else begin
                case (state)
                    tci_pkg::ST_RX: begin
                        // a repeated start rise shifts one bit; the start then clears it
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s}; // [RULE11] [RULE14]
                            cnt <= cnt + 4'h1;
                        end else if (byte_done) begin
                            cnt <= 4'h0;
                            if (ph == tci_pkg::PH_ADDR && !addr_hit) begin
                                state <= tci_pkg::ST_IDLE; // [RULE9]
                            end else begin
                                state <= tci_pkg::ST_ACK;
                                drv <= 1'b1; // [RULE8]
                            end
                            case (ph)
                                tci_pkg::PH_ADDR: rnw <= shift[0];
                                tci_pkg::PH_PHI: ptr[15:8] <= shift; // [RULE14] [RULE17]
                                tci_pkg::PH_PLO: ptr[7:0] <= shift;
                                default: begin
                                    wr_data_o <= shift; // [RULE13]
                                    wr_en_o <= 1'b1;
                                end
                            endcase
                        end
                    end

                    tci_pkg::ST_ACK: begin
                        // fetch on the fall so bit 7 is out before SCL rises again
                        if (scl_fall && pass_ack) begin
                            tx <= rd_data_i; // [RULE18]
                            rd_en_o <= 1'b1;
                            ptr <= ptr + 16'h0001;
                            cnt <= 4'h0;
                            drv <= ~rd_data_i[7];
                            state <= tci_pkg::ST_TX;
                        end else if (scl_fall) begin
                            drv <= 1'b0;
                            state <= tci_pkg::ST_RX;
                            if (ph == tci_pkg::PH_DATA) begin
                                ptr <= ptr + 16'h0001; // [RULE15] [RULE16]
                            end else begin
                                ph <= ph + 2'h1;
                            end
                        end
                    end

                    tci_pkg::ST_TX: begin
                        if (scl_fall && cnt == tci_pkg::LAST_TX_BIT) begin
                            drv <= 1'b0;
                            state <= tci_pkg::ST_MACK;
                        end else if (scl_fall) begin
                            tx <= {tx[6:0], 1'b0};
                            drv <= ~tx[6]; // [RULE11] [RULE21]
                            cnt <= cnt + 4'h1;
                        end
                    end

                    tci_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            nak <= sda_s;
                        end else if (scl_fall && !nak) begin
                            tx <= rd_data_i; // [RULE19]
                            rd_en_o <= 1'b1;
                            ptr <= ptr + 16'h0001;
                            cnt <= 4'h0;
                            drv <= ~rd_data_i[7];
                            state <= tci_pkg::ST_TX;
                        end else if (scl_fall) begin
                            state <= tci_pkg::ST_IDLE; // [RULE20]
                        end
                    end

                    default: begin
                        drv <= 1'b0;
                        state <= tci_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // tci_dev

// *** rtl/tci_host.sv ***
// host end: two-wire master issuing burst writes and burst reads, each starting with a pointer write
`timescale 1ns/1ps
module tci_host #(
    parameter int QTR = tci_pkg::QTR_CYC
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    tci_if.host link,
    input wire logic addr_sel_i,
    input wire logic go_i,
    input wire logic rnw_i,
    input wire logic [tci_pkg::PTR_W-1:0] reg_i,
    input wire logic [7:0] len_i,
    input wire logic [7:0] wdata_i,
    output logic wdata_take_o,
    output logic [7:0] rdata_o,
    output logic rdata_vld_o,
    output logic nak_o,
    output logic busy_o
);
    tci_pkg::tci_host_e hst;
    logic sda_s;
    logic [15:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] tx9;
    logic [8:0] rx9;
    logic [2:0] stage;
    logic [7:0] left;
    logic rnw_r;
    logic [tci_pkg::PTR_W-1:0] reg_r;
    logic sel_r;
    logic scl_low;
    logic sda_low;

    tci_sync #(.W(1)) u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(link.sda),
        .q_o(sda_s)
    );

    wire tick = (qcnt == 16'(QTR - 1));
    wire [7:0] dev_w = sel_r ? tci_pkg::ADDR_PAIR_B : tci_pkg::ADDR_PAIR_A; // [RULE3]
    wire last = (left == 8'h01);
    wire acked = ~rx9[0];

    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe = scl_low;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = sda_low;
    // strap level follows the select input even in reset, so it is valid at release
    assign link.evt_sel = addr_sel_i; // [RULE4]
    assign busy_o = (hst != tci_pkg::H_IDLE);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            qcnt <= 16'h0000;
        end else begin
            qcnt <= (hst == tci_pkg::H_IDLE || tick) ? 16'h0000 : qcnt + 16'h0001; // [RULE2]
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hst <= tci_pkg::H_IDLE;
            q <= 2'h0;
            bitn <= 4'h0;
            tx9 <= 9'h1FF;
            rx9 <= 9'h000;
            stage <= tci_pkg::STG_ADDRW;
            left <= 8'h00;
            rnw_r <= 1'b0;
            reg_r <= 16'h0000;
            sel_r <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            nak_o <= 1'b0;
            rdata_o <= 8'h00;
            rdata_vld_o <= 1'b0;
            wdata_take_o <= 1'b0;
        end else begin
            rdata_vld_o <= 1'b0;
            wdata_take_o <= 1'b0;
            if (tick) begin
                q <= q + 2'h1;
            end
            case (hst)
                tci_pkg::H_IDLE: begin
                    sel_r <= addr_sel_i;
                    q <= 2'h0;
                    if (go_i) begin
                        hst <= tci_pkg::H_START;
                        stage <= tci_pkg::STG_ADDRW;
                        rnw_r <= rnw_i;
                        reg_r <= reg_i;
                        left <= len_i;
                        nak_o <= 1'b0;
                        tx9 <= {dev_w, 1'b1}; // [RULE13] [RULE17]
                    end
                end
                tci_pkg::H_START: begin
                    // also serves as repeated start from SCL low
                    if (tick) begin
                        case (q)
                            2'h0: sda_low <= 1'b0;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b1; // [RULE6]
                            default: begin
                                scl_low <= 1'b1;
                                bitn <= 4'h0;
                                hst <= tci_pkg::H_BITS;
                            end
                        endcase
                    end
                end
                tci_pkg::H_BITS: begin
                    if (tick) begin
                        case (q)
                            2'h0: sda_low <= ~tx9[8]; // [RULE11] [RULE14]
                            2'h1: scl_low <= 1'b0;
                            2'h2: rx9 <= {rx9[7:0], sda_s};
                            default: begin
                                scl_low <= 1'b1;
                                bitn <= bitn + 4'h1;
                                tx9 <= {tx9[7:0], 1'b1};
                                if (bitn == tci_pkg::BYTE_BITS) begin // [RULE10]
                                    bitn <= 4'h0;
                                    if (stage != tci_pkg::STG_RDATA && !acked) begin
                                        nak_o <= 1'b1;
                                        hst <= tci_pkg::H_STOP;
                                    end else begin
                                        case (stage)
                                            tci_pkg::STG_ADDRW: begin
                                                stage <= tci_pkg::STG_HI;
                                                tx9 <= {reg_r[15:8], 1'b1}; // [RULE14]
                                            end
                                            tci_pkg::STG_HI: begin
                                                stage <= tci_pkg::STG_LO;
                                                tx9 <= {reg_r[7:0], 1'b1};
                                            end
                                            tci_pkg::STG_LO: begin
                                                if (rnw_r) begin
                                                    stage <= tci_pkg::STG_ADDRR;
                                                    hst <= tci_pkg::H_START; // [RULE18]
                                                    tx9 <= {dev_w[7:1], 1'b1, 1'b1};
                                                end else begin
                                                    stage <= tci_pkg::STG_WDATA;
                                                    tx9 <= {wdata_i, 1'b1};
                                                    wdata_take_o <= 1'b1;
                                                end
                                            end
                                            tci_pkg::STG_WDATA: begin
                                                left <= left - 8'h01;
                                                if (last) begin
                                                    hst <= tci_pkg::H_STOP;
                                                end else begin
                                                    tx9 <= {wdata_i, 1'b1};
                                                    wdata_take_o <= 1'b1;
                                                end
                                            end
                                            tci_pkg::STG_ADDRR: begin
                                                stage <= tci_pkg::STG_RDATA;
                                                tx9 <= {8'hFF, last}; // [RULE20]
                                            end
                                            default: begin
                                                rdata_o <= rx9[8:1];
                                                rdata_vld_o <= 1'b1;
                                                left <= left - 8'h01;
                                                if (last) begin
                                                    hst <= tci_pkg::H_STOP;
                                                end else begin
                                                    tx9 <= {8'hFF, left == 8'h02}; // [RULE19]
                                                end
                                            end
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                tci_pkg::H_STOP: begin
                    if (tick) begin
                        case (q)
                            2'h0: sda_low <= 1'b1;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b0; // [RULE12]
                            default: hst <= tci_pkg::H_IDLE;
                        endcase
                    end
                end
                default: hst <= tci_pkg::H_IDLE;
            endcase
        end
    end
endmodule // tci_host

// *** test/tci_link_properties.sv ***
// concurrent checks on the resolved two-wire link between host and device ends
`timescale 1ns/1ps
module tci_link_properties (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic evt_sel
);
    logic scl_q, sda_q, idle, in_addr, rnw, hit, sel;
    logic [3:0] bitc;
    logic [7:0] addr;
    wire logic rise = scl && !scl_q;
    wire logic start = scl && scl_q && sda_q && !sda;
    wire logic stop = scl && scl_q && !sda_q && sda;
    wire logic [7:0] pair = sel ? 8'h28 : 8'hBA;
    wire logic match = addr[7:1] == pair[7:1];
    wire logic slot9 = rise && bitc == 4'h8;
    // select level copied while reset is held, mirrors the latch in the device
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sel <= evt_sel;
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            idle <= 1'b1;
            in_addr <= 1'b0;
            bitc <= 4'h0;
            addr <= 8'h00;
            rnw <= 1'b0;
            hit <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                idle <= 1'b0;
                in_addr <= 1'b1;
                bitc <= 4'h0;
            end else if (stop) begin
                idle <= 1'b1;
            end else if (rise) begin
                bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
                if (in_addr && bitc != 4'h8) begin
                    addr <= {addr[6:0], sda};
                end
                if (in_addr && bitc == 4'h8) begin
                    in_addr <= 1'b0;
                    rnw <= addr[0];
                    hit <= match;
                end
            end
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_idle_quiet;
        idle |-> !sda_dev_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("device drives data line on idle bus");
    property p_low_only;
        sda_dev_oe |-> !sda_dev_o;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("device drives data line high");
    property p_change_low;
        $changed(sda_dev_oe) |-> !scl;
    endproperty
    a_change_low: assert property (p_change_low)
        else $error("device changed data line while clock high");
    property p_addr_quiet;
        in_addr && bitc < 4'h8 |-> !sda_dev_oe;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("device drives during address bits");
    property p_addr_ack;
        in_addr && slot9 |-> sda_dev_oe == match;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge does not follow match");
    property p_nomatch_quiet;
        !in_addr && !idle && !hit |-> !sda_dev_oe;
    endproperty
    a_nomatch_quiet: assert property (p_nomatch_quiet)
        else $error("device active after foreign address");
    property p_wr_ack;
        !in_addr && hit && !rnw && slot9 |-> sda_dev_oe;
    endproperty
    a_wr_ack: assert property (p_wr_ack)
        else $error("written byte not acknowledged");
    property p_rd_release;
        !in_addr && hit && rnw && slot9 |-> !sda_dev_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("device holds data line in host acknowledge slot");
    property p_drive_hold;
        $rose(sda_dev_oe) |=> sda_dev_oe [*8];
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("device low drive shorter than a clock low phase");
endmodule // tci_link_properties

// *** test/testbench.sv ***
// self-checking bench joining host and touch controller ends over the link
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic addr_sel = 1'b0;
    logic go = 1'b0;
    logic rnw = 1'b0;
    logic [15:0] reg_a = 16'h0000;
    logic [7:0] len = 8'h01;
    logic [7:0] wdata = 8'h00;
    logic wtake, rvld, nak, h_busy, wr_en, rd_en, d_busy;
    logic [7:0] rdata, wr_data, pair;
    logic [15:0] reg_addr;
    logic [7:0] mem [0:255];
    logic [7:0] wbuf [0:7];
    logic [23:0] wlog [$];
    logic [7:0] rlog [$];
    int widx = 0;
    int n_rd = 0;
    int failures = 0;
    int n_checks = 0;
    // device side register space, read combinationally at the pointer
    wire logic [7:0] rd_data = mem[reg_addr[7:0]];
    tci_if link_if ();
    tci_host #(.QTR(4)) tci_host_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link(link_if.host), .addr_sel_i(addr_sel), .go_i(go), .rnw_i(rnw), .reg_i(reg_a),
        .len_i(len), .wdata_i(wdata), .wdata_take_o(wtake), .rdata_o(rdata),
        .rdata_vld_o(rvld), .nak_o(nak), .busy_o(h_busy));
    tci_dev tci_dev_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(link_if.dev),
        .reg_addr_o(reg_addr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en),
        .rd_data_i(rd_data), .busy_o(d_busy), .addr_pair_o(pair));
    tci_link_properties tci_link_properties_inst (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .scl(link_if.scl), .sda(link_if.sda),
        .sda_dev_o(link_if.sda_dev_o), .sda_dev_oe(link_if.sda_dev_oe),
        .evt_sel(link_if.evt_sel));
    always #5 ref_clk_i = ~ref_clk_i;
    // each take consumes the byte on offer, so the next one is put up at once
    always @(posedge ref_clk_i) begin
        if (wtake === 1'b1) begin
            wdata <= wbuf[widx];
            widx <= widx + 1;
        end
        if (wr_en === 1'b1) begin
            mem[reg_addr[7:0]] <= wr_data;
            wlog.push_back({reg_addr, wr_data});
        end
        if (rvld === 1'b1) begin
            rlog.push_back(rdata);
        end
        if (rd_en === 1'b1) begin
            n_rd <= n_rd + 1;
        end
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic r, input logic [15:0] a, input logic [7:0] n);
        int i;
        @(posedge ref_clk_i);
        go <= 1'b1;
        rnw <= r;
        reg_a <= a;
        len <= n;
        wdata <= wbuf[0];
        widx <= 1;
        n_rd <= 0;
        wlog.delete();
        rlog.delete();
        @(posedge ref_clk_i);
        go <= 1'b0;
        @(negedge ref_clk_i);
        for (i = 0; i < 8000 && (h_busy !== 1'b0 || d_busy !== 1'b0); i++) begin
            @(negedge ref_clk_i);
        end
        if (i == 8000) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic t_burst_write();
        wbuf[0] = 8'h3C;
        wbuf[1] = 8'hC3;
        wbuf[2] = 8'h7E;
        xfer(1'b0, 16'h12FE, 8'h03);
        check("write count", 24'h3, 24'(wlog.size()));
        for (int i = 0; i < 3; i++) begin
            check("write", {16'h12FE + 16'(i), wbuf[i]}, wlog[i]);
        end
        check("pointer", 24'h001301, {8'h00, reg_addr});
        check("nak", 24'h0, {23'h0, nak});
    endtask
    task automatic t_burst_read();
        logic [7:0] exp [4] = '{8'h3C, 8'hC3, 8'h7E, 8'hA4};
        xfer(1'b1, 16'h12FE, 8'h04);
        check("read count", 24'h4, 24'(rlog.size()));
        for (int i = 0; i < 4; i++) begin
            check("read", {16'h0, exp[i]}, {16'h0, rlog[i]});
        end
        check("read writes", 24'h0, 24'(wlog.size()));
        check("device loads", 24'h4, 24'(n_rd));
        check("pointer", 24'h001302, {8'h00, reg_addr});
    endtask
    task automatic t_single_read();
        xfer(1'b1, 16'h00FF, 8'h01);
        check("read count", 24'h1, 24'(rlog.size()));
        check("read", 24'h0000C3, {16'h0, rlog[0]});
        check("device loads", 24'h1, 24'(n_rd));
        check("pointer", 24'h000100, {8'h00, reg_addr});
    endtask
    task automatic t_wrong_pair();
        @(posedge ref_clk_i);
        addr_sel <= 1'b1;
        wbuf[0] = 8'h99;
        xfer(1'b0, 16'h0010, 8'h01);
        check("nak", 24'h1, {23'h0, nak});
        check("write count", 24'h0, 24'(wlog.size()));
        check("pair", 24'h0000BA, {16'h0, pair});
        check("untouched", 24'h0000B5, {16'h0, mem[16]});
    endtask
    task automatic t_reset_pair();
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check("pair", 24'h000028, {16'h0, pair});
        wbuf[0] = 8'h55;
        wbuf[1] = 8'hAA;
        xfer(1'b0, 16'h0040, 8'h02);
        check("nak", 24'h0, {23'h0, nak});
        check("write", 24'h004055, wlog[0]);
        check("write", 24'h0041AA, wlog[1]);
    endtask
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = 8'(k) ^ 8'hA5;
        end
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        t_burst_write();
        t_burst_read();
        t_single_read();
        t_wrong_pair();
        t_reset_pair();
        stop_test();
    end
endmodule // testbench
